// File: design/ixbar_pkg.sv
// shared constants and carrier types of the inter-module signal crossbar
package ixbar_pkg;

  // ***********************************
  // crossbar geometry
  // ***********************************
  localparam int unsigned IXBAR_NUM_IN    = 22;
  localparam int unsigned IXBAR_NUM_OUT   = 7;
  localparam int unsigned IXBAR_SEL_W     = 5;
  localparam int unsigned IXBAR_SEL_SLOTS = 32;
  localparam int unsigned IXBAR_NUM_PINS  = 6;

  // input indices
  localparam int unsigned IXBAR_IN_ZERO    = 0;
  localparam int unsigned IXBAR_IN_ONE     = 1;
  localparam int unsigned IXBAR_IN_PIN0    = 2;
  localparam int unsigned IXBAR_IN_UNUSED  = 8;
  localparam int unsigned IXBAR_IN_CMP0    = 9;
  localparam int unsigned IXBAR_IN_TMR0    = 12;
  localparam int unsigned IXBAR_IN_MOD0    = 16;
  localparam int unsigned IXBAR_IN_MOD1    = 17;
  localparam int unsigned IXBAR_IN_MOD2    = 18;
  localparam int unsigned IXBAR_IN_MOD_ANY = 19;
  localparam int unsigned IXBAR_IN_MOD3_T0 = 20;
  localparam int unsigned IXBAR_IN_MOD3_T1 = 21;

  // output indices
  localparam int unsigned IXBAR_OUT_PIN0  = 0;
  localparam int unsigned IXBAR_OUT_PIN1  = 1;
  localparam int unsigned IXBAR_OUT_CONVA = 6;

  // ***********************************
  // comparator input selectors
  // ***********************************
  localparam int unsigned IXBAR_NUM_CMP     = 3;
  localparam int unsigned IXBAR_CMP_SRCS    = 4;
  localparam int unsigned IXBAR_CMP_SEL_W   = 2;
  localparam int unsigned IXBAR_WORD_W      = 12;
  localparam logic [1:0]  IXBAR_CMP_POS_DAC = 2'h1;
  localparam logic [1:0]  IXBAR_CMP_NEG_DAC = 2'h3;

  // reset values
  localparam logic [4:0]  IXBAR_SEL_RST     = 5'h00;
  localparam logic [1:0]  IXBAR_CMP_SEL_RST = 2'h0;
  localparam logic        IXBAR_EXTB_RST    = 1'h0;

  // ***********************************
  // types
  // ***********************************
  typedef enum logic [1:0] {
    IXBAR_PF_GPIO,
    IXBAR_PF_I2C,
    IXBAR_PF_SWITCH
  } ixbar_pin_func_t;

  // modulator trigger outputs, unit n trigger 0 and 1
  typedef struct packed {
    logic [3:0][1:0] trig;
  } ixbar_trig_t;

  // converter results and limits
  typedef struct packed {
    logic                    result_valid;
    logic [IXBAR_WORD_W-1:0] slot1;
    logic [IXBAR_WORD_W-1:0] slot2;
    logic [IXBAR_WORD_W-1:0] low1;
    logic [IXBAR_WORD_W-1:0] low2;
    logic [IXBAR_WORD_W-1:0] high2;
  } ixbar_limit_t;

  // all state of the top module except the reset release flops
  typedef struct packed {
    logic [IXBAR_NUM_PINS-1:0]                      pin_meta;
    logic [IXBAR_NUM_PINS-1:0]                      pin_sync;
    logic [IXBAR_NUM_OUT-1:0][IXBAR_SEL_W-1:0]      out_sel;
    ixbar_pin_func_t [1:0]                          pin_func;
    logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SEL_W-1:0] cmp_pos_sel;
    logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SEL_W-1:0] cmp_neg_sel;
    logic                                           ext_b1;
    logic                                           ext_b2;
  } ixbar_state_t;

endpackage : ixbar_pkg

// File: design/ixbar_sel.sv
// parameterised n-to-1 selector used by the crossbar and comparator inputs
`timescale 1ns/100ps
module ixbar_sel
  import ixbar_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter int unsigned N = 4
) (
  // sources and choice
  input  logic [N-1:0][W-1:0]   src,
  input  logic [$clog2(N)-1:0]  sel,
  // selected source
  output logic [W-1:0]          y
);

  // ***********************************
  // selection
  // ***********************************
  // purely combinational, so a routed edge keeps its timing
  assign y = src[sel];

endmodule : ixbar_sel

// File: design/ixbar_top.sv
// inter-module signal crossbar with comparator selectors and limit compare
`timescale 1ns/100ps
module ixbar_top
  import ixbar_pkg::*;
(
  // clock and reset
  input  logic                                           core_clk,
  input  logic                                           rst_b,
  // software selections
  input  logic [IXBAR_NUM_OUT-1:0][IXBAR_SEL_W-1:0]      out_sel,
  input  ixbar_pin_func_t [1:0]                          pin_func,
  input  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SEL_W-1:0] cmp_pos_sel,
  input  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SEL_W-1:0] cmp_neg_sel,
  // crossbar sources
  input  logic [IXBAR_NUM_PINS-1:0]                      switch_pin_input,
  input  logic [IXBAR_NUM_CMP-1:0]                       comparator_result,
  input  logic [3:0]                                     timer_b_channel_output,
  input  ixbar_trig_t                                    mod_trig,
  // pin functions sharing the pins of outputs 0 and 1
  input  logic [1:0]                                     port_c_gpio_out,
  input  logic [1:0]                                     port_c_gpio_oe,
  input  logic [1:0]                                     i2c_drive_low,
  // comparator analog sources as codes
  input  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SRCS-1:0][IXBAR_WORD_W-1:0] cmp_pos_src,
  input  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SRCS-1:0][IXBAR_WORD_W-1:0] cmp_neg_src,
  input  logic [IXBAR_WORD_W-1:0]                        dac_code,
  // converter results and limits
  input  ixbar_limit_t                                   conv,
  // crossbar outputs
  output logic [IXBAR_NUM_OUT-1:0]                       switch_output,
  output logic                                           converter_a_trigger,
  output logic [1:0]                                     port_c_pin_out,
  output logic [1:0]                                     port_c_pin_oe,
  // comparator inputs
  output logic [IXBAR_NUM_CMP-1:0][IXBAR_WORD_W-1:0]     cmp_pos_word,
  output logic [IXBAR_NUM_CMP-1:0][IXBAR_WORD_W-1:0]     cmp_neg_word,
  // modulator external sources
  output logic                                           modulator_unit1_external_b_source,
  output logic                                           modulator_unit2_external_b_source
);

  // ***********************************
  // reset release
  // ***********************************
  logic rst_meta_b_ff;
  logic rst_sync_b_ff;

  // assert at once, release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_b_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_b_ff;
    end
  end

  // ***********************************
  // state
  // ***********************************
  ixbar_state_t st_ff;
  ixbar_state_t nxt_st;

  // next state: selections, pin sync and limit compare
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.pin_meta    = switch_pin_input;
    nxt_st.pin_sync    = st_ff.pin_meta;
    nxt_st.out_sel     = out_sel;
    nxt_st.pin_func    = pin_func;
    nxt_st.cmp_pos_sel = cmp_pos_sel;
    nxt_st.cmp_neg_sel = cmp_neg_sel;
    // a result inside the limits keeps the last level
    if (conv.result_valid) begin
      if (conv.slot2 > conv.high2) begin
        nxt_st.ext_b2 = 1'b0;
      end else if (conv.slot2 < conv.low2) begin
        nxt_st.ext_b2 = 1'b1;
      end
      if (conv.slot1 < conv.low1) begin
        nxt_st.ext_b1 = 1'b1;
      end
    end
  end

  // register the state; defaults return on every reset
  always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      st_ff.pin_meta    <= '0;
      st_ff.pin_sync    <= '0;
      st_ff.out_sel     <= {IXBAR_NUM_OUT{IXBAR_SEL_RST}};
      st_ff.pin_func[0] <= IXBAR_PF_GPIO;
      st_ff.pin_func[1] <= IXBAR_PF_GPIO;
      st_ff.cmp_pos_sel <= {IXBAR_NUM_CMP{IXBAR_CMP_SEL_RST}};
      st_ff.cmp_neg_sel <= {IXBAR_NUM_CMP{IXBAR_CMP_SEL_RST}};
      st_ff.ext_b1      <= IXBAR_EXTB_RST;
      st_ff.ext_b2      <= IXBAR_EXTB_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ***********************************
  // crossbar inputs
  // ***********************************
  logic [IXBAR_SEL_SLOTS-1:0] switch_input;
  logic [2:0]                 unit_trigger_or;

  // each of units 0 to 2 has its two triggers merged; unit 3's triggers stay separate
  always_comb begin
    for (int u = 0; u < 3; u++) begin
      unit_trigger_or[u] = mod_trig.trig[u][0] | mod_trig.trig[u][1];
    end
  end

  // fixed input assignment; unused and spare slots read zero
  always_comb begin
    switch_input                                    = '0;
    switch_input[IXBAR_IN_ZERO]                     = 1'b0;
    switch_input[IXBAR_IN_ONE]                      = 1'b1;
    switch_input[IXBAR_IN_PIN0 +: IXBAR_NUM_PINS]   = st_ff.pin_sync;
    switch_input[IXBAR_IN_UNUSED]                   = 1'b0;
    switch_input[IXBAR_IN_CMP0 +: IXBAR_NUM_CMP]    = comparator_result;
    switch_input[IXBAR_IN_TMR0 +: 4]                = timer_b_channel_output;
    switch_input[IXBAR_IN_MOD0]                     = unit_trigger_or[0];
    switch_input[IXBAR_IN_MOD1]                     = unit_trigger_or[1];
    switch_input[IXBAR_IN_MOD2]                     = unit_trigger_or[2];
    switch_input[IXBAR_IN_MOD_ANY]                  = |unit_trigger_or;
    switch_input[IXBAR_IN_MOD3_T0]                  = mod_trig.trig[3][0];
    switch_input[IXBAR_IN_MOD3_T1]                  = mod_trig.trig[3][1];
  end

  // ***********************************
  // crossbar outputs
  // ***********************************
  genvar g;
  generate
    for (g = 0; g < IXBAR_NUM_OUT; g++) begin : g_out
      // no flop in the path, so a trigger reaches its sink in the same cycle
      ixbar_sel #(
        .W (1),
        .N (IXBAR_SEL_SLOTS)
      ) u_out_sel (
        .src (switch_input),
        .sel (st_ff.out_sel[g]),
        .y   (switch_output[g])
      );
    end
  endgenerate

  assign converter_a_trigger = switch_output[IXBAR_OUT_CONVA];

  // shared pins: gpio function after reset, crossbar only once reselected
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      port_c_pin_out[p] = 1'b0;
      port_c_pin_oe[p]  = 1'b0;
      unique case (st_ff.pin_func[p])
        IXBAR_PF_GPIO: begin
          port_c_pin_out[p] = port_c_gpio_out[p];
          port_c_pin_oe[p]  = port_c_gpio_oe[p];
        end
        IXBAR_PF_I2C: begin
          port_c_pin_out[p] = 1'b0;                                            // open drain
          port_c_pin_oe[p]  = i2c_drive_low[p];
        end
        IXBAR_PF_SWITCH: begin
          port_c_pin_out[p] = switch_output[IXBAR_OUT_PIN0 + p];
          port_c_pin_oe[p]  = 1'b1;
        end
        default: begin
          port_c_pin_out[p] = 1'b0;                                            // illegal code floats
          port_c_pin_oe[p]  = 1'b0;
        end
      endcase
    end
  end

  // ***********************************
  // comparator input selectors
  // ***********************************
  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SRCS-1:0][IXBAR_WORD_W-1:0] pos_src_dac;
  logic [IXBAR_NUM_CMP-1:0][IXBAR_CMP_SRCS-1:0][IXBAR_WORD_W-1:0] neg_src_dac;

  // the shared dac replaces positive source 1 and negative source 3
  always_comb begin
    pos_src_dac = cmp_pos_src;
    neg_src_dac = cmp_neg_src;
    for (int c = 0; c < IXBAR_NUM_CMP; c++) begin
      pos_src_dac[c][IXBAR_CMP_POS_DAC] = dac_code;
      neg_src_dac[c][IXBAR_CMP_NEG_DAC] = dac_code;
    end
  end

  generate
    for (g = 0; g < IXBAR_NUM_CMP; g++) begin : g_cmp
      ixbar_sel #(
        .W (IXBAR_WORD_W),
        .N (IXBAR_CMP_SRCS)
      ) u_pos_sel (
        .src (pos_src_dac[g]),
        .sel (st_ff.cmp_pos_sel[g]),
        .y   (cmp_pos_word[g])
      );
      ixbar_sel #(
        .W (IXBAR_WORD_W),
        .N (IXBAR_CMP_SRCS)
      ) u_neg_sel (
        .src (neg_src_dac[g]),
        .sel (st_ff.cmp_neg_sel[g]),
        .y   (cmp_neg_word[g])
      );
    end
  endgenerate

  // ***********************************
  // modulator external sources
  // ***********************************
  assign modulator_unit1_external_b_source = st_ff.ext_b1;
  assign modulator_unit2_external_b_source = st_ff.ext_b2;

endmodule : ixbar_top

// File: test/ixbar_bench.sv
// self-checking bench of the crossbar with peripheral model
`timescale 1ns/100ps
module ixbar_bench
  import ixbar_pkg::*;
;
  typedef struct {int kind; int idx; logic [11:0] exp;} ixbar_note_t;
  logic                  core_clk, rst_b, go, eb1, eb2, ctrig, b1, b2;
  logic [6:0][4:0]       out_sel;
  ixbar_pin_func_t [1:0] pin_func;
  logic [2:0][1:0]       cps, cns;
  logic [2:0][3:0][11:0] psrc, nsrc;
  logic [2:0][11:0]      pw, nw;
  logic [14:0]           pat;
  logic [11:0]           dac;
  logic [6:0]            sw;
  logic [5:0]            pins;
  logic [3:0]            tmr;
  logic [2:0]            cmpr;
  logic [1:0]            g_out, g_oe, i2c, pin_out, pin_oe;
  ixbar_trig_t           trig;
  ixbar_limit_t          lim, conv;
  ixbar_note_t           notes[$];
  ixbar_note_t           nt;
  int                    n_fail, checked;
  ixbar_periph_model PEER (.core_clk, .pat, .go, .lim, .mod_trig(trig), .tmr, .cmp(cmpr), .conv);
  ixbar_top DUT (.core_clk, .rst_b, .out_sel, .pin_func, .cmp_pos_sel(cps), .cmp_neg_sel(cns),
    .switch_pin_input(pins), .comparator_result(cmpr), .timer_b_channel_output(tmr), .mod_trig(trig),
    .port_c_gpio_out(g_out), .port_c_gpio_oe(g_oe), .i2c_drive_low(i2c), .cmp_pos_src(psrc),
    .cmp_neg_src(nsrc), .dac_code(dac), .conv, .switch_output(sw), .converter_a_trigger(ctrig),
    .port_c_pin_out(pin_out), .port_c_pin_oe(pin_oe), .cmp_pos_word(pw), .cmp_neg_word(nw),
    .modulator_unit1_external_b_source(b1), .modulator_unit2_external_b_source(b2));
  // 200 mhz clock
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // ***
  // helpers
  // ***
  function automatic logic [11:0] r4();
    return 12'($urandom % 16); // narrow range so limits tie and cross often
  endfunction : r4
  task automatic push(input int k, input int i, input logic [11:0] e);
    notes.push_back('{k, i, e});
  endtask : push
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: bit %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk_word
  // sweep of selects: 7 is odd, so each output walks all 32 codes
  task automatic shuffle(input int i);
    for (int o = 0; o < 7; o++) out_sel[o] <= 5'((i * 7 + o) % 32);
    for (int c = 0; c < 3; c++) begin
      cps[c] <= 2'($urandom);
      cns[c] <= 2'($urandom);
      for (int s = 0; s < 4; s++) begin
        psrc[c][s] <= 12'($urandom);
        nsrc[c][s] <= 12'($urandom);
      end
    end
    // all three legal pin functions, so the open-drain path is exercised too
    for (int p = 0; p < 2; p++) pin_func[p] <= ixbar_pin_func_t'($urandom % 3);
    pat <= 15'($urandom);
    pins <= 6'($urandom);
    dac <= 12'($urandom);
    g_out <= 2'($urandom);
    g_oe <= 2'($urandom);
    i2c <= 2'($urandom);
    lim <= '{1'b0, r4(), r4(), r4(), r4(), r4()};
  endtask : shuffle
  // one routing step; pins need two edges of sync before they show
  task automatic step(input int i);
    logic [31:0] x;
    int          s;
    bit          fire;
    @(negedge core_clk);
    shuffle(i);
    fire = 1'($urandom);
    go <= fire;
    @(negedge core_clk);
    go <= 1'b0;
    repeat (2) @(negedge core_clk);
    x = {10'h0, pat[7:6], |pat[5:0], |pat[5:4], |pat[3:2], |pat[1:0], pat[11:8], pat[14:12], 1'b0, pins, 2'b10};
    for (int o = 0; o < 7; o++) begin
      s = out_sel[o];
      push(s inside {[16:18]} ? 1 : s == 19 ? 2 : s inside {20, 21} ? 3 : s inside {[12:15]} ? 4 : 11, o, 12'(x[s]));
    end
    push(12, 0, 12'(x[out_sel[6]]));
    for (int c = 0; c < 3; c++) begin
      push(6, c, cps[c] == IXBAR_CMP_POS_DAC ? dac : psrc[c][cps[c]]);
      push(6, c + 3, cns[c] == IXBAR_CMP_NEG_DAC ? dac : nsrc[c][cns[c]]);
    end
    for (int p = 0; p < 2; p++)
      push(10, p, pin_func[p] == IXBAR_PF_SWITCH ? {10'h0, 1'b1, x[out_sel[p]]} :
                  pin_func[p] == IXBAR_PF_I2C ? {10'h0, i2c[p], 1'b0} : {10'h0, g_oe[p], g_out[p]});
    if (fire) begin
      if (lim.slot2 > lim.high2) eb2 = 1'b0;
      else if (lim.slot2 < lim.low2) eb2 = 1'b1;
      if (lim.slot1 < lim.low1) eb1 = 1'b1;
    end
    push(7, 0, 12'(eb2));
    push(9, 0, 12'(eb1));
  endtask : step
  // ***
  // result watcher
  // ***
  always @(posedge core_clk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        1: chk_bit(sw[nt.idx], nt.exp[0]);
        2: chk_bit(sw[nt.idx], nt.exp[0]);
        3: chk_bit(sw[nt.idx], nt.exp[0]);
        4: chk_bit(sw[nt.idx], nt.exp[0]);
        11: chk_bit(sw[nt.idx], nt.exp[0]);
        12: chk_bit(ctrig, nt.exp[0]);
        6: chk_word(nt.idx < 3 ? pw[nt.idx] : nw[nt.idx - 3], nt.exp);
        7: chk_bit(b2, nt.exp[0]);
        9: chk_bit(b1, nt.exp[0]);
        default: chk_word({10'h0, pin_oe[nt.idx], pin_out[nt.idx]}, nt.exp);
      endcase
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // the run needs about 166 cycles; fifteen times that is a hang
  initial begin
    #12500;
    n_fail++;
    finish_test();
  end
  // main sequence: ports say switch, but reset must keep gpio and zero
  initial begin
    void'($urandom(83));
    rst_b = 1'b0;
    go = 1'b0;
    eb1 = 1'b0;
    eb2 = 1'b0;
    shuffle(1);
    pin_func[0] <= IXBAR_PF_SWITCH;
    pin_func[1] <= IXBAR_PF_SWITCH;
    @(negedge core_clk);
    for (int p = 0; p < 2; p++) push(10, p, {10'h0, g_oe[p], g_out[p]});
    push(11, 0, 12'h0);
    push(7, 0, 12'h0);
    push(9, 0, 12'h0);
    @(negedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 40; i++) step(i);
    @(negedge core_clk);
    finish_test();
  end
endmodule : ixbar_bench

// File: test/ixbar_periph_model.sv
// behavioural model of the peripherals around the crossbar
`timescale 1ns/100ps
module ixbar_periph_model
  import ixbar_pkg::*;
(
  // clock and requested values
  input  logic         core_clk,
  input  logic [14:0]  pat,
  input  logic         go,
  input  ixbar_limit_t lim,
  // peripheral outputs
  output ixbar_trig_t  mod_trig,
  output logic [3:0]   tmr,
  output logic [2:0]   cmp,
  output ixbar_limit_t conv
);
  // ***
  // launch flops
  // ***
  // quiet until the first launch
  initial begin
    mod_trig = '0;
    tmr = 4'h0;
    cmp = 3'h0;
    conv = '0;
  end
  // one falling edge late, as a peripheral launching from its own flop
  always @(negedge core_clk) begin
    mod_trig <= pat[7:0];
    tmr <= pat[11:8];
    cmp <= pat[14:12];
    conv <= '{go, lim.slot1, lim.slot2, lim.low1, lim.low2, lim.high2}; // single-cycle result strobe
  end
endmodule : ixbar_periph_model

// File: test/ixbar_props.sv
// concurrent checks on the crossbar top ports
`timescale 1ns/100ps
module ixbar_props
  import ixbar_pkg::*;
(
  // clock and reset
  input logic             core_clk,
  input logic             rst_b,
  // selections and sources
  input logic [6:0][4:0]  out_sel,
  input logic [2:0][1:0]  cmp_pos_sel,
  input logic [3:0]       timer_b_channel_output,
  input ixbar_trig_t      mod_trig,
  input logic [11:0]      dac_code,
  input ixbar_limit_t     conv,
  // watched outputs
  input logic [6:0]       switch_output,
  input logic             converter_a_trigger,
  input logic [2:0][11:0] cmp_pos_word,
  input logic             modulator_unit1_external_b_source,
  input logic             modulator_unit2_external_b_source
);
  // ***
  // settle window
  // ***
  // selections count only from the third edge after release
  logic [1:0] settle_ff;
  logic       rdy;
  assign rdy = (settle_ff == 2'h3);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) settle_ff <= 2'h0;
    else if (!rdy) settle_ff <= settle_ff + 2'h1;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_or0;
    rdy && out_sel[0] == 5'h10 |=> switch_output[0] == |mod_trig.trig[0];
  endproperty
  a_or0: assert property (p_or0) else $error("unit 0 trigger or lost");
  property p_u3;
    rdy && out_sel[2] == 5'h14 |=> switch_output[2] == mod_trig.trig[3][0];
  endproperty
  a_u3: assert property (p_u3) else $error("unit 3 trigger 0 lost");
  property p_tmr;
    rdy && out_sel[4] inside {[5'h0c:5'h0f]} |=> switch_output[4] == timer_b_channel_output[$past(out_sel[4][1:0])];
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer channel order wrong");
  property p_conv;
    rdy && out_sel[6] == 5'h01 |=> converter_a_trigger && switch_output[6];
  endproperty
  a_conv: assert property (p_conv) else $error("converter trigger wrong");
  property p_dac;
    rdy && cmp_pos_sel[0] == IXBAR_CMP_POS_DAC |=> cmp_pos_word[0] == dac_code;
  endproperty
  a_dac: assert property (p_dac) else $error("dac not on positive input");
  property p_hi2;
    rdy && conv.result_valid && conv.slot2 > conv.high2 |=> !modulator_unit2_external_b_source;
  endproperty
  a_hi2: assert property (p_hi2) else $error("unit 2 source not low");
  property p_lo2;
    rdy && conv.result_valid && conv.slot2 < conv.low2 && conv.slot2 <= conv.high2
      |=> modulator_unit2_external_b_source;
  endproperty
  a_lo2: assert property (p_lo2) else $error("unit 2 source not high");
  property p_lo1;
    rdy && conv.result_valid && conv.slot1 < conv.low1 |=> modulator_unit1_external_b_source;
  endproperty
  a_lo1: assert property (p_lo1) else $error("unit 1 source not high");
endmodule : ixbar_props
bind ixbar_top ixbar_props u_props (.core_clk, .rst_b, .out_sel, .cmp_pos_sel, .timer_b_channel_output,
  .mod_trig, .dac_code, .conv, .switch_output, .converter_a_trigger, .cmp_pos_word,
  .modulator_unit1_external_b_source, .modulator_unit2_external_b_source);
